// file: hw/alarm_input_sync.v
// Two flip-flop synchroniser for a bundle of asynchronous alarm levels.
// Assumes the levels are quasi-static; each bit is synchronised on its own.
`timescale 1ns/1ps

module alarm_input_sync #(
    parameter WIDTH = 7
) (
    input  wire             core_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] async_level,
    output reg  [WIDTH-1:0] sync_level
);

    reg [WIDTH-1:0] meta_stage;

    // =================================================================
    // Synchroniser stages
    // =================================================================
    always @(posedge core_clk) begin
        if (sys_rst) begin
            meta_stage <= {WIDTH{1'b0}};
            sync_level <= {WIDTH{1'b0}};
        end else begin
            meta_stage <= async_level;
            sync_level <= meta_stage;
        end
    end

endmodule

// file: hw/clock_alarm_regs.vh
// Register map, field positions and reset values of the alarm status block.
// Included by the status flags module only, not by the synchroniser or the flag bank; definitions only.
`ifndef CLOCK_ALARM_REGS_VH
`define CLOCK_ALARM_REGS_VH

// =====================================================================
// Register offsets
// =====================================================================
`define LIVE_ALARM_STATUS_OFS        8'h82
`define SIGNAL_LOSS_STICKY_OFS       8'h83
`define OFFSET_LOCK_STICKY_OFS       8'h84
`define PART_IDENTITY_UPPER_OFS      8'h86

// =====================================================================
// Live status field positions
// =====================================================================
`define LIVE_HOLDOVER_VALID_BIT      6
`define LIVE_INPUT_TWO_OFFSET_BIT    2
`define LIVE_INPUT_ONE_OFFSET_BIT    1
`define LIVE_PLL_UNLOCK_BIT          0

// =====================================================================
// Signal loss flag field positions
// =====================================================================
`define LOSS_INPUT_TWO_BIT           2
`define LOSS_INPUT_ONE_BIT           1
`define LOSS_REFERENCE_BIT           0

// =====================================================================
// Offset and lock flag field positions
// =====================================================================
`define OFS_INPUT_TWO_BIT            3
`define OFS_INPUT_ONE_BIT            2
`define OFS_PLL_UNLOCK_BIT           1

// =====================================================================
// Widths and reset values
// =====================================================================
`define REG_WIDTH                    8
`define LIVE_SOURCE_COUNT            7
`define REG_RESET_VALUE              8'h00
// Arbitrary neutral identity value
`define PART_IDENTITY_UPPER_DEFAULT  8'h5a

`endif

// file: hw/clock_alarm_status_flags.v
// Alarm status, held flags and interrupt gating of the clock multiplier.
// Assumes a serial control port decoder presents byte accesses on reg_*,
// and that live alarm levels arrive asynchronously from the detectors.
// Mask and enable levels come from registers on core_clk, unsynchronised.
//
// Behaviour
// (RL1) Live status bit 6 reads 1 once the holdover history is filled, else 0.
// (RL2) Live status bit 2 reads 1 while input two has a frequency offset alarm.
// (RL3) Live status bit 1 reads 1 while input one has a frequency offset alarm.
// (RL4) Live status bit 0 reads 1 while the PLL is unlocked and 0 while locked.
// (RL5) Signal loss flag bit 2 holds the live loss indicator of input two.
// (RL6) Signal loss flag bit 1 holds the live loss indicator of input one.
// (RL7) Signal loss flag bit 0 holds the live loss indicator of the reference.
// (RL8) Offset and lock flag bit 3 holds the live offset indicator of input two.
// (RL9) Offset and lock flag bit 2 holds the live offset indicator of input one.
// (RL10) Offset and lock flag bit 1 holds the live PLL unlock indicator.
// (RL11) A held flag clears only when the host writes zero to its bit.
// (RL12) The interrupt rises for any unmasked held flag while the pin is enabled.
// (RL13) Live signal loss indicators for input two, input one and reference read 1 in alarm.
// (RL14) A flag cleared while its live indicator is active stays set; the set wins in the same cycle.
// (RL15) Reserved bits of status, flag and identity registers read zero and ignore writes.
`timescale 1ns/1ps
`include "clock_alarm_regs.vh"

module clock_alarm_status_flags #(
    parameter [7:0] PART_IDENTITY_UPPER = `PART_IDENTITY_UPPER_DEFAULT
) (
    input  wire       core_clk,
    input  wire       sys_rst,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output reg        reg_rd_valid,
    input  wire       holdover_history_valid,
    input  wire       input_two_offset_live,
    input  wire       input_one_offset_live,
    input  wire       pll_unlock_live,
    input  wire       input_two_signal_loss_live,
    input  wire       input_one_signal_loss_live,
    input  wire       reference_signal_loss_live,
    input  wire       irq_pin_enable,
    input  wire       input_two_signal_loss_mask,
    input  wire       input_one_signal_loss_mask,
    input  wire       reference_signal_loss_mask,
    input  wire       input_two_offset_mask,
    input  wire       input_one_offset_mask,
    input  wire       pll_unlock_mask,
    output reg        irq_out,
    output reg  [7:0] live_alarm_status,
    output reg  [7:0] live_signal_loss,
    output reg        pll_unlock_alarm,
    output reg        signal_loss_alarm
);

    // =================================================================
    // Helper functions
    // =================================================================
    function addr_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // Gated interrupt contribution of a flag group
    function group_request;
        input [2:0] flags;
        input [2:0] masks;
        begin
            group_request = |(flags & ~masks);
        end
    endfunction

    // =================================================================
    // Declarations
    // =================================================================
    wire [6:0] raw_live;
    wire [6:0] sync_live;
    wire       sync_holdover_valid;
    wire       sync_two_offset;
    wire       sync_one_offset;
    wire       sync_pll_unlock;
    wire       sync_two_loss;
    wire       sync_one_loss;
    wire       sync_ref_loss;

    wire       write_signal_loss;
    wire       write_offset_lock;
    wire [2:0] loss_live_set;
    wire [2:0] loss_clear_data;
    wire [2:0] loss_held;
    wire [2:0] ofs_live_set;
    wire [2:0] ofs_clear_data;
    wire [2:0] ofs_held;

    wire [2:0] loss_masks;
    wire [2:0] ofs_masks;
    wire       loss_request;
    wire       ofs_request;

    reg  [7:0] next_live_status;
    reg  [7:0] next_live_loss;
    reg  [7:0] loss_flag_byte;
    reg  [7:0] ofs_flag_byte;
    reg  [7:0] next_rdata;
    reg        next_irq;

    // =================================================================
    // Synchronise live alarm levels
    // =================================================================
    // Every consumer reads the synced copy, so set and clear share one domain
    assign raw_live = {holdover_history_valid,
                       input_two_offset_live,
                       input_one_offset_live,
                       pll_unlock_live,
                       input_two_signal_loss_live,
                       input_one_signal_loss_live,
                       reference_signal_loss_live};

    alarm_input_sync #(
        .WIDTH (`LIVE_SOURCE_COUNT)
    ) live_sync (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .async_level (raw_live),
        .sync_level  (sync_live)
    );

    assign sync_holdover_valid = sync_live[6];
    assign sync_two_offset     = sync_live[5];
    assign sync_one_offset     = sync_live[4];
    assign sync_pll_unlock     = sync_live[3];
    assign sync_two_loss       = sync_live[2];
    assign sync_one_loss       = sync_live[1];
    assign sync_ref_loss       = sync_live[0];

    // =================================================================
    // Live status bytes
    // =================================================================
    // Live bytes register on the same edge as the held flags, one stage after the synchroniser
    always @* begin
        next_live_status = `REG_RESET_VALUE; // RL15
        next_live_status[`LIVE_HOLDOVER_VALID_BIT]   = sync_holdover_valid; // RL1
        next_live_status[`LIVE_INPUT_TWO_OFFSET_BIT] = sync_two_offset; // RL2
        next_live_status[`LIVE_INPUT_ONE_OFFSET_BIT] = sync_one_offset; // RL3
        next_live_status[`LIVE_PLL_UNLOCK_BIT]       = sync_pll_unlock; // RL4
    end

    always @* begin
        next_live_loss = `REG_RESET_VALUE;
        next_live_loss[`LOSS_INPUT_TWO_BIT] = sync_two_loss; // RL13
        next_live_loss[`LOSS_INPUT_ONE_BIT] = sync_one_loss; // RL13
        next_live_loss[`LOSS_REFERENCE_BIT] = sync_ref_loss; // RL13
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            live_alarm_status <= `REG_RESET_VALUE;
            live_signal_loss  <= `REG_RESET_VALUE;
        end else begin
            live_alarm_status <= next_live_status;
            live_signal_loss  <= next_live_loss;
        end
    end

    // =================================================================
    // Host write decode
    // =================================================================
    // Writes to read-only or unmapped bytes decode to nothing
    assign write_signal_loss = reg_wr & addr_hit(reg_addr, `SIGNAL_LOSS_STICKY_OFS);
    assign write_offset_lock = reg_wr & addr_hit(reg_addr, `OFFSET_LOCK_STICKY_OFS);

    // =================================================================
    // Signal loss held flags
    // =================================================================
    // Set wins over a clear while the level is still active
    assign loss_live_set = {sync_two_loss, // RL5
                            sync_one_loss, // RL6
                            sync_ref_loss}; // RL7

    assign loss_clear_data = {reg_wdata[`LOSS_INPUT_TWO_BIT],
                              reg_wdata[`LOSS_INPUT_ONE_BIT],
                              reg_wdata[`LOSS_REFERENCE_BIT]};

    sticky_flag_bank #(
        .WIDTH (3)
    ) loss_flags (
        .core_clk     (core_clk),
        .sys_rst      (sys_rst),
        .live_set     (loss_live_set), // RL14
        .clear_strobe (write_signal_loss), // RL11
        .clear_data   (loss_clear_data),
        .held         (loss_held)
    );

    // =================================================================
    // Offset and lock held flags
    // =================================================================
    // Same clear rule as the loss bank
    assign ofs_live_set = {sync_two_offset, // RL8
                           sync_one_offset, // RL9
                           sync_pll_unlock}; // RL10

    assign ofs_clear_data = {reg_wdata[`OFS_INPUT_TWO_BIT],
                             reg_wdata[`OFS_INPUT_ONE_BIT],
                             reg_wdata[`OFS_PLL_UNLOCK_BIT]};

    sticky_flag_bank #(
        .WIDTH (3)
    ) ofs_flags (
        .core_clk     (core_clk),
        .sys_rst      (sys_rst),
        .live_set     (ofs_live_set), // RL14
        .clear_strobe (write_offset_lock), // RL11
        .clear_data   (ofs_clear_data),
        .held         (ofs_held)
    );

    // =================================================================
    // Flag register images
    // =================================================================
    // Held bits at their register positions, the rest zero
    always @* begin
        loss_flag_byte = `REG_RESET_VALUE; // RL15
        loss_flag_byte[`LOSS_INPUT_TWO_BIT] = loss_held[2];
        loss_flag_byte[`LOSS_INPUT_ONE_BIT] = loss_held[1];
        loss_flag_byte[`LOSS_REFERENCE_BIT] = loss_held[0];
    end

    always @* begin
        ofs_flag_byte = `REG_RESET_VALUE; // RL15
        ofs_flag_byte[`OFS_INPUT_TWO_BIT]  = ofs_held[2];
        ofs_flag_byte[`OFS_INPUT_ONE_BIT]  = ofs_held[1];
        ofs_flag_byte[`OFS_PLL_UNLOCK_BIT] = ofs_held[0];
    end

    // =================================================================
    // Read path
    // =================================================================
    // A read sharing a cycle with a write sees the value before the write
    // Last read data stands until the next read
    always @* begin
        next_rdata = reg_rdata;
        if (reg_rd) begin
            if (addr_hit(reg_addr, `LIVE_ALARM_STATUS_OFS)) begin
                next_rdata = live_alarm_status;
            end else if (addr_hit(reg_addr, `SIGNAL_LOSS_STICKY_OFS)) begin
                next_rdata = loss_flag_byte;
            end else if (addr_hit(reg_addr, `OFFSET_LOCK_STICKY_OFS)) begin
                next_rdata = ofs_flag_byte;
            end else if (addr_hit(reg_addr, `PART_IDENTITY_UPPER_OFS)) begin
                next_rdata = PART_IDENTITY_UPPER;
            end else begin
                next_rdata = `REG_RESET_VALUE;
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata    <= `REG_RESET_VALUE;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rdata    <= next_rdata;
            reg_rd_valid <= reg_rd;
        end
    end

    // =================================================================
    // Interrupt gating
    // =================================================================
    assign loss_masks = {input_two_signal_loss_mask,
                         input_one_signal_loss_mask,
                         reference_signal_loss_mask};

    assign ofs_masks = {input_two_offset_mask,
                        input_one_offset_mask,
                        pll_unlock_mask};

    // Each group contributes only its unmasked held flags
    assign loss_request = group_request(loss_held, loss_masks); // RL12
    assign ofs_request  = group_request(ofs_held, ofs_masks); // RL12

    always @* begin
        next_irq = irq_pin_enable & (loss_request | ofs_request); // RL12
    end

    // =================================================================
    // Alarm outputs
    // =================================================================
    // Summary alarms follow the synced levels, not the held flags
    always @(posedge core_clk) begin
        if (sys_rst) begin
            irq_out           <= 1'b0;
            pll_unlock_alarm  <= 1'b0;
            signal_loss_alarm <= 1'b0;
        end else begin
            irq_out           <= next_irq; // RL12
            pll_unlock_alarm  <= sync_pll_unlock; // RL4
            signal_loss_alarm <= sync_two_loss | sync_one_loss | sync_ref_loss;
        end
    end

endmodule

// file: hw/sticky_flag_bank.v
// Bank of held alarm flags: set by a live level, cleared by writing zero.
// Assumes set levels and the clear strobe are on core_clk.
`timescale 1ns/1ps

module sticky_flag_bank #(
    parameter WIDTH = 3
) (
    input  wire             core_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] live_set,
    input  wire             clear_strobe,
    input  wire [WIDTH-1:0] clear_data,
    output reg  [WIDTH-1:0] held
);

    reg [WIDTH-1:0] next_held;

    // =================================================================
    // Flag update, set wins over clear
    // =================================================================
    always @* begin
        next_held = held;
        if (clear_strobe) begin
            next_held = held & clear_data;
        end
        next_held = next_held | live_set;
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            held <= {WIDTH{1'b0}};
        end else begin
            held <= next_held;
        end
    end

endmodule

// file: test/clock_alarm_status_flags_properties.sv
// Concurrent checks on the alarm status block, top-level ports only.
// Assumes binding into clock_alarm_status_flags; live inputs reach status in 3 edges.
`timescale 1ns/1ps
module clock_alarm_status_flags_properties (
    input wire       core_clk,
    input wire       sys_rst,
    input wire       reg_wr,
    input wire       holdover_history_valid,
    input wire       input_two_offset_live,
    input wire       input_one_offset_live,
    input wire       pll_unlock_live,
    input wire       input_two_signal_loss_live,
    input wire       input_one_signal_loss_live,
    input wire       reference_signal_loss_live,
    input wire       irq_pin_enable,
    input wire       input_two_signal_loss_mask,
    input wire       input_one_signal_loss_mask,
    input wire       reference_signal_loss_mask,
    input wire       input_two_offset_mask,
    input wire       input_one_offset_mask,
    input wire       pll_unlock_mask,
    input wire       irq_out,
    input wire [7:0] live_alarm_status,
    input wire [7:0] live_signal_loss
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire [5:0] lv = {input_two_signal_loss_live, input_one_signal_loss_live, reference_signal_loss_live,
                     input_two_offset_live, input_one_offset_live, pll_unlock_live};
    wire [5:0] mk = {input_two_signal_loss_mask, input_one_signal_loss_mask, reference_signal_loss_mask,
                     input_two_offset_mask, input_one_offset_mask, pll_unlock_mask};
    reg  [2:0] up;
    // =====================================================================
    // Cycles since reset, so the sync chain holds real samples
    // =====================================================================
    always @(posedge core_clk) begin
        if (sys_rst)
            up <= 3'h0;
        else if (up != 3'h4)
            up <= up + 3'h1;
    end
    sequence s_unmasked_alarm;
        up == 3'h4 && |($past(lv, 4) & ~$past(mk)) && $past(irq_pin_enable);
    endsequence
    sequence s_irq_undisturbed;
        irq_out && !$past(reg_wr) && $stable(irq_pin_enable) && $stable(mk);
    endsequence
    a_holdover_bit: assert property (up == 3'h4 |-> live_alarm_status[6] == $past(holdover_history_valid, 3))
        else $error("holdover bit does not follow its input");
    a_offset_bits: assert property (up == 3'h4 |-> live_alarm_status[2:1] == $past(lv[2:1], 3))
        else $error("offset bits do not follow their inputs");
    a_unlock_bit: assert property (up == 3'h4 |-> live_alarm_status[0] == $past(lv[0], 3))
        else $error("unlock bit does not follow its input");
    a_loss_live_byte: assert property (up == 3'h4 |-> live_signal_loss == {5'h00, $past(lv[5:3], 3)})
        else $error("live loss byte wrong");
    a_status_reserved_zero: assert property ((live_alarm_status & 8'hb8) == 8'h00)
        else $error("reserved status bits set");
    a_irq_on_alarm: assert property (s_unmasked_alarm |-> irq_out)
        else $error("interrupt missing for unmasked alarm");
    a_irq_pin_off: assert property (!$past(irq_pin_enable) |-> !irq_out)
        else $error("interrupt while pin disabled");
    a_flag_stays_held: assert property (s_irq_undisturbed |=> irq_out)
        else $error("held flag dropped without a write");
endmodule

bind clock_alarm_status_flags clock_alarm_status_flags_properties chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .holdover_history_valid(holdover_history_valid),
    .input_two_offset_live(input_two_offset_live), .input_one_offset_live(input_one_offset_live),
    .pll_unlock_live(pll_unlock_live), .input_two_signal_loss_live(input_two_signal_loss_live),
    .input_one_signal_loss_live(input_one_signal_loss_live),
    .reference_signal_loss_live(reference_signal_loss_live), .irq_pin_enable(irq_pin_enable),
    .input_two_signal_loss_mask(input_two_signal_loss_mask),
    .input_one_signal_loss_mask(input_one_signal_loss_mask),
    .reference_signal_loss_mask(reference_signal_loss_mask), .input_two_offset_mask(input_two_offset_mask),
    .input_one_offset_mask(input_one_offset_mask), .pll_unlock_mask(pll_unlock_mask), .irq_out(irq_out),
    .live_alarm_status(live_alarm_status), .live_signal_loss(live_signal_loss));

// file: test/host_port_model.sv
// Host side of the byte register port: single reads and writes.
// Assumes core_clk; drives on falling edges, one idle cycle between accesses.
`timescale 1ns/1ps
module host_port_model (
    input  wire       core_clk,
    output reg  [7:0] reg_addr,
    output reg        reg_wr,
    output reg  [7:0] reg_wdata,
    output reg        reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task access(input bit w, input [7:0] a, input [7:0] d);
        begin
            @(negedge core_clk);
            reg_addr = a;
            reg_wdata = w ? d : ~reg_wdata;
            reg_wr = w;
            reg_rd = !w;
            @(negedge core_clk);
            reg_wr = 1'b0;
            reg_rd = 1'b0;
            // Released lines do not keep the old value
            reg_addr = ~a;
            reg_wdata = ~reg_wdata;
        end
    endtask
endmodule

// file: test/test_clock_alarm_status_flags.sv
// Self-checking bench of the alarm status block with a host port model.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((e) !== (a)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, a); end end
module test_clock_alarm_status_flags;
    localparam [7:0] ID = 8'h3c; // Arbitrary identity value
    reg        core_clk, sys_rst, en;
    reg  [6:0] live;
    reg  [5:0] msk;
    reg  [2:0] loss_s, ofs_s;
    reg  [7:0] w, got_e;
    reg  [7:0] expq[$];
    wire [7:0] reg_addr, reg_wdata, reg_rdata, live_alarm_status, live_signal_loss;
    wire       reg_wr, reg_rd, reg_rd_valid, irq_out, pll_unlock_alarm, signal_loss_alarm;
    integer    seed, fails, check_count, cycles, i;
    clock_alarm_status_flags #(.PART_IDENTITY_UPPER(ID)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .holdover_history_valid(live[6]),
        .input_two_offset_live(live[5]), .input_one_offset_live(live[4]), .pll_unlock_live(live[3]),
        .input_two_signal_loss_live(live[2]), .input_one_signal_loss_live(live[1]),
        .reference_signal_loss_live(live[0]), .irq_pin_enable(en), .input_two_signal_loss_mask(msk[5]),
        .input_one_signal_loss_mask(msk[4]), .reference_signal_loss_mask(msk[3]),
        .input_two_offset_mask(msk[2]), .input_one_offset_mask(msk[1]), .pll_unlock_mask(msk[0]),
        .irq_out(irq_out), .live_alarm_status(live_alarm_status), .live_signal_loss(live_signal_loss),
        .pll_unlock_alarm(pll_unlock_alarm), .signal_loss_alarm(signal_loss_alarm));
    host_port_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd));
    task final_report;
        begin
            $display("Checks %0d, mismatches %0d", check_count, fails);
            if (fails == 0 && check_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            expq.push_back(e);
            host.access(1'b0, a, 8'h00);
        end
    endtask
    task settle;
        repeat (6) @(negedge core_clk);
    endtask
    // =====================================================================
    // Clock, timeout and read-data monitor
    // =====================================================================
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            final_report;
        end
    end
    always @(negedge core_clk) begin
        if (reg_rd_valid === 1'b1) begin
            got_e = expq.size() > 0 ? expq.pop_front() : 8'hxx;
            `CHK("reg_rdata", got_e, reg_rdata)
        end
    end
    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        seed = 5;
        fails = 0;
        check_count = 0;
        cycles = 0;
        sys_rst = 1'b1;
        live = 7'h00;
        msk = 6'h00;
        en = 1'b0;
        loss_s = 3'h0;
        ofs_s = 3'h0;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        rd(8'h86, ID);
        host.access(1'b1, 8'h86, 8'hff);
        host.access(1'b1, 8'h82, 8'hff);
        rd(8'h86, ID);
        rd(8'h85, 8'h00);
        rd(8'h82, 8'h00);
        for (i = 0; i < 16; i++) begin
            live = 7'($random(seed));
            msk = 6'($random(seed));
            en = 1'($random(seed));
            settle;
            loss_s = loss_s | live[2:0];
            ofs_s = ofs_s | live[5:3];
            `CHK("live_signal_loss", {5'h00, live[2:0]}, live_signal_loss)
            `CHK("pll_unlock_alarm", live[3], pll_unlock_alarm)
            `CHK("signal_loss_alarm", |live[2:0], signal_loss_alarm)
            `CHK("irq_out", en & |({loss_s, ofs_s} & ~msk), irq_out)
            rd(8'h82, {1'b0, live[6], 3'h0, live[5:3]});
            rd(8'h83, {5'h00, loss_s});
            rd(8'h84, {4'h0, ofs_s, 1'b0});
            w = 8'($random(seed));
            host.access(1'b1, 8'h83, w);
            host.access(1'b1, 8'h84, ~w);
            loss_s = (loss_s & w[2:0]) | live[2:0];
            ofs_s = (ofs_s & ~w[3:1]) | live[5:3];
            settle;
            `CHK("irq_out", en & |({loss_s, ofs_s} & ~msk), irq_out)
            rd(8'h83, {5'h00, loss_s});
            rd(8'h84, {4'h0, ofs_s, 1'b0});
        end
        settle;
        `CHK("pending reads", 0, expq.size())
        final_report;
    end
endmodule
